// File: rtl/fiap_pkg.sv
// Shared constants and types for the flash page program/read sequencer
package fiap_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;               // Flash word address width
  localparam int WORD_W = 16;               // Flash word width
  localparam int IDX_W = 5;                 // Word index inside a page
  localparam int PAGE_W = ADDR_W - IDX_W;   // Page number width
  localparam int PAGE_WORDS = 32;           // Words per page and buffer
  localparam int FIFO_DEPTH = 32;           // Stream FIFO depth
  localparam logic [IDX_W-1:0] IDX_LAST = 5'h1F; // Last word of a page

  // ----------------------------------------------------------------
  // Operation select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_WRITE = 3'h0;   // Buffer to flash write
  localparam logic [2:0] OP_ERASE = 3'h1;   // Page erase
  localparam logic [2:0] OP_READ = 3'h3;    // Single word read

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 10;              // System clock rate
  localparam int EW_SHORT_US = 1000;        // Short erase/write time
  localparam int EW_LONG_US = 2000;         // Long erase/write time
  localparam logic [15:0] EW_SHORT_CYC = 16'(EW_SHORT_US * CLK_MHZ);
  localparam logic [15:0] EW_LONG_CYC = 16'(EW_LONG_US * CLK_MHZ);
  localparam int READ_INSTR = 3;            // Read time, instr cycles
  localparam int CLK_PER_INSTR = 1;         // Clocks per instr cycle
  localparam logic [15:0] READ_CYC = 16'(READ_INSTR * CLK_PER_INSTR);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_WRITE,
    ST_READ
  } fiapState_t;

  // One word bound for the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } fiapWord_t;

endpackage

// File: rtl/fiap_top.sv
// Flash page program/read sequencer with its word stream FIFO
`timescale 1ns/1ps
// Functional notes
// R1: 32-word buffer mapped to addressed page
// R2: Software loads address, then low, high
// R3: Each word load advances buffer address
// R4: Address saturates at page's last word
// R5: Select code 001 means page erase
// R6: Select code 000 means buffer write
// R7: Clear strobe zeroes the whole buffer
// R8: Erase trigger self-clears when erase done
// R9: Write trigger self-clears when programming done
// R10: Trigger duration chosen by time select
// R11: CPU stalled until erase/write ends
// R12: Erase/write only with enabled flag high
// R13: Erase always clears a whole page
// R14: Write commits whole buffer within page
// R15: Rewrite without erase is accepted
// R16: Clearing enabled flag blocks erase/write
// R17: Select 011 plus enable means read
// R18: Read fetches word, trigger drops after
// R19: Read needs no enabled flag
// R20: Read takes three cycles, CPU stalled
// R21: Software runs fastest clock while programming
// R22: Low byte write only updates low register
// R23: Dummy high writes tag, address saturating
// R24: Unlock success sets enabled flag

// ------------------------------------------------------------------
// Stream FIFO
// ------------------------------------------------------------------
module fiap_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  // Whole FIFO state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fiapFifoSt_t;

  fiapFifoSt_t s_q; // Registered state
  fiapFifoSt_t s_d; // Next state
  logic push;       // Word accepted
  logic pop;        // Word delivered

  // Honest full and empty
  assign inReady = (s_q.cnt != (PW+1)'(DEPTH));
  assign outValid = (s_q.cnt != '0);
  assign outData = s_q.mem[s_q.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Next state
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = inData;
      s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ------------------------------------------------------------------
// Sequencer
// ------------------------------------------------------------------
module fiap_top #(
  parameter logic [15:0] EW_SHORT_CYC = fiap_pkg::EW_SHORT_CYC,
  parameter logic [15:0] EW_LONG_CYC = fiap_pkg::EW_LONG_CYC,
  parameter int FIFO_DEPTH = fiap_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // CPU register writes
  input wire logic [7:0] wrData,
  input wire logic addrLowWr,
  input wire logic addrHighWr,
  input wire logic dataLowWr,
  input wire logic dataHighWr,
  // CPU control bits
  input wire logic [2:0] flashOpSelect,
  input wire logic readFunctionEnable,
  input wire logic eraseWriteTimeSelect,
  input wire logic clearWriteBuffer,
  input wire logic eraseWriteTriggerSet,
  input wire logic readTriggerSet,
  input wire logic unlockSuccess,
  input wire logic enabledFlagClear,
  // CPU status
  output logic eraseWriteEnabledFlag,
  output logic eraseWriteTrigger,
  output logic readTrigger,
  output logic cpuStall,
  output logic [fiap_pkg::ADDR_W-1:0] flashAddr,
  output logic [7:0] data0Low,
  output logic [7:0] data0High,
  // Array erase and read
  output logic arrayErase,
  output logic [fiap_pkg::PAGE_W-1:0] arrayErasePage,
  input wire logic [fiap_pkg::WORD_W-1:0] arrayReadData,
  // Array program stream
  output logic progValid,
  input wire logic progReady,
  output fiap_pkg::fiapWord_t progWord
);

  // Whole sequencer state
  typedef struct packed {
    fiap_pkg::fiapState_t st;
    logic [fiap_pkg::PAGE_WORDS-1:0][fiap_pkg::WORD_W-1:0] buffer;
    logic [fiap_pkg::ADDR_W-1:0] addr;
    logic [7:0] dLow;
    logic [7:0] dHigh;
    logic ewFlag;
    logic ewTrig;
    logic rdTrig;
    logic eraseReq;
    logic [15:0] cnt;
    logic [fiap_pkg::IDX_W:0] idx;
  } fiapSt_t;

  fiapSt_t s_q;                // Registered state
  fiapSt_t s_d;                // Next state
  logic pushReady;             // FIFO has room
  logic pushValid;             // Word offered to FIFO
  fiap_pkg::fiapWord_t pushWord; // Word offered
  logic [fiap_pkg::IDX_W-1:0] idxLow; // Buffer index being streamed

  // Page/word split of a flash address
  function automatic logic [fiap_pkg::IDX_W-1:0] wordOf(
    input logic [fiap_pkg::ADDR_W-1:0] a);
    wordOf = a[fiap_pkg::IDX_W-1:0];
  endfunction

  function automatic logic [fiap_pkg::PAGE_W-1:0] pageOf(
    input logic [fiap_pkg::ADDR_W-1:0] a);
    pageOf = a[fiap_pkg::ADDR_W-1:fiap_pkg::IDX_W];
  endfunction

  // ----------------------------------------------------------------
  // Stream towards the array
  // ----------------------------------------------------------------
  assign idxLow = s_q.idx[fiap_pkg::IDX_W-1:0];
  assign pushValid = (s_q.st == fiap_pkg::ST_WRITE) &&
                     (s_q.idx != (fiap_pkg::IDX_W+1)'(fiap_pkg::PAGE_WORDS));
  // Whole page from buffer, page number from the address [R14]
  assign pushWord.addr = {pageOf(s_q.addr), idxLow};
  assign pushWord.data = s_q.buffer[idxLow];

  fiap_fifo #(
    .WIDTH($bits(fiap_pkg::fiapWord_t)),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushWord),
    .outValid(progValid),
    .outReady(progReady),
    .outData(progWord)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.eraseReq = 1'b0;
    // Hardware sets flag on unlock, set wins over clear [R24] [R16]
    if (unlockSuccess) begin
      s_d.ewFlag = 1'b1;
    end else if (enabledFlagClear) begin
      s_d.ewFlag = 1'b0;
    end
    case (s_q.st)
      fiap_pkg::ST_IDLE: begin
        // Address pair loads
        if (addrLowWr) begin
          s_d.addr[7:0] = wrData;
        end
        if (addrHighWr) begin
          s_d.addr[fiap_pkg::ADDR_W-1:8] = wrData[fiap_pkg::ADDR_W-9:0];
        end
        // Low byte only stored in its register [R22]
        if (dataLowWr) begin
          s_d.dLow = wrData;
        end
        // Buffer clear; rewrites need no erase [R7] [R15]
        if (clearWriteBuffer) begin
          s_d.buffer = '0;
        end
        // High byte loads word and tags address [R1] [R2] [R22] [R23]
        if (dataHighWr) begin
          s_d.dHigh = wrData;
          s_d.buffer[wordOf(s_q.addr)] = {wrData, s_d.dLow};
          // Advance, saturating at last word of page [R3] [R4]
          if (wordOf(s_q.addr) != fiap_pkg::IDX_LAST) begin
            s_d.addr = s_q.addr + 1'b1;
          end
        end
        // Erase/write start needs enabled flag [R12] [R16]
        if (eraseWriteTriggerSet && s_q.ewFlag) begin
          s_d.cnt = eraseWriteTimeSelect ? EW_LONG_CYC : EW_SHORT_CYC; // [R10]
          if (flashOpSelect == fiap_pkg::OP_ERASE) begin
            // Whole page erase [R5] [R13]
            s_d.st = fiap_pkg::ST_ERASE;
            s_d.ewTrig = 1'b1;
            s_d.eraseReq = 1'b1;
          end else if (flashOpSelect == fiap_pkg::OP_WRITE) begin
            s_d.st = fiap_pkg::ST_WRITE; // [R6]
            s_d.ewTrig = 1'b1;
            s_d.idx = '0;
          end
        end else if (readTriggerSet &&
                     flashOpSelect == fiap_pkg::OP_READ &&
                     readFunctionEnable) begin
          // Read mode, no flag needed [R17] [R19]
          s_d.st = fiap_pkg::ST_READ;
          s_d.rdTrig = 1'b1;
          s_d.cnt = fiap_pkg::READ_CYC;
        end
      end
      fiap_pkg::ST_ERASE: begin
        // Trigger self-clears after the selected time [R8]
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0001) begin
          s_d.st = fiap_pkg::ST_IDLE;
          s_d.ewTrig = 1'b0;
        end
      end
      fiap_pkg::ST_WRITE: begin
        if (s_q.cnt != 16'h0000) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
        if (pushValid && pushReady) begin
          s_d.idx = s_q.idx + 1'b1;
        end
        // Done once time is up and every word reached the array [R9]
        if (s_q.cnt <= 16'h0001 && !pushValid && !progValid) begin
          s_d.st = fiap_pkg::ST_IDLE;
          s_d.ewTrig = 1'b0;
          s_d.cnt = 16'h0000;
        end
      end
      fiap_pkg::ST_READ: begin
        // Three cycles, then word captured and trigger dropped [R18] [R20]
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0001) begin
          s_d.st = fiap_pkg::ST_IDLE;
          s_d.rdTrig = 1'b0;
          s_d.dLow = arrayReadData[7:0];
          s_d.dHigh = arrayReadData[15:8];
        end
      end
      default: begin
        s_d.st = fiap_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= fiap_pkg::ST_IDLE;
      s_q.addr <= fiap_pkg::ADDR_RST;
      s_q.dLow <= fiap_pkg::DATA_RST;
      s_q.dHigh <= fiap_pkg::DATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // CPU halts during erase, write and read [R11] [R20]
  assign cpuStall = (s_q.st != fiap_pkg::ST_IDLE);
  assign eraseWriteEnabledFlag = s_q.ewFlag;
  assign eraseWriteTrigger = s_q.ewTrig;
  assign readTrigger = s_q.rdTrig;
  assign flashAddr = s_q.addr;
  assign data0Low = s_q.dLow;
  assign data0High = s_q.dHigh;
  assign arrayErase = s_q.eraseReq;
  assign arrayErasePage = pageOf(s_q.addr);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_readStart;
    $rose(readTrigger);
  endsequence

  sequence s_readHeld;
    readTrigger [*3] ##1 !readTrigger;
  endsequence

  property p_readTiming;
    s_readStart |-> s_readHeld;
  endproperty
  a_readTiming: assert property (p_readTiming) // [R20]
    else $error("read trigger not three cycles");

  property p_readData;
    $fell(readTrigger) |->
      {data0High, data0Low} == $past(arrayReadData);
  endproperty
  a_readData: assert property (p_readData) // [R18]
    else $error("read data not captured");

  property p_noStartWithoutFlag;
    (!eraseWriteEnabledFlag && !cpuStall) |=> !eraseWriteTrigger;
  endproperty
  a_noStartWithoutFlag: assert property (p_noStartWithoutFlag) // [R12]
    else $error("erase/write started without flag");

  property p_stall;
    (eraseWriteTrigger || readTrigger) |-> cpuStall;
  endproperty
  a_stall: assert property (p_stall) // [R11]
    else $error("cpu not stalled");

  property p_advance;
    (dataHighWr && !cpuStall && flashAddr[4:0] != 5'h1F) |=>
      flashAddr == $past(flashAddr) + 13'h0001;
  endproperty
  a_advance: assert property (p_advance) // [R3]
    else $error("address did not advance");

  property p_saturate;
    (dataHighWr && !cpuStall && flashAddr[4:0] == 5'h1F &&
     !addrLowWr && !addrHighWr) |=> $stable(flashAddr);
  endproperty
  a_saturate: assert property (p_saturate) // [R4]
    else $error("address left page");

  property p_eraseLen;
    $rose(arrayErase) |-> eraseWriteTrigger [*8];
  endproperty
  a_eraseLen: assert property (p_eraseLen) // [R8]
    else $error("erase trigger dropped early");

  property p_unlock;
    unlockSuccess |=> eraseWriteEnabledFlag;
  endproperty
  a_unlock: assert property (p_unlock) // [R24]
    else $error("flag not set on unlock");

  property p_progPage;
    progValid |-> progWord.addr[12:5] == flashAddr[12:5];
  endproperty
  a_progPage: assert property (p_progPage) // [R14]
    else $error("program word off page");

endmodule

// File: verif/fiap_flash_model.sv
// Flash array model: page erase, program stream and word read
`timescale 1ns/1ps
module fiap_flash_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pacing: 0 prompt, 1 alternate cycles, 2 hold off
  input wire logic [1:0] pace,
  // Sequencer side
  input wire logic arrayErase,
  input wire logic [fiap_pkg::PAGE_W-1:0] arrayErasePage,
  input wire logic [fiap_pkg::ADDR_W-1:0] flashAddr,
  input wire logic readTrigger,
  input wire logic progValid,
  output logic progReady,
  input wire fiap_pkg::fiapWord_t progWord,
  output logic [fiap_pkg::WORD_W-1:0] arrayReadData
);
  logic [fiap_pkg::WORD_W-1:0] mem [2**fiap_pkg::ADDR_W]; // Array words
  logic tick_q; // Toggles every cycle
  // Ready pacing, slow modes stall the stream
  assign progReady = (pace == 2'h0) || (pace == 2'h1 && tick_q);
  // Data only while a read runs, churning pattern otherwise
  assign arrayReadData = readTrigger ? mem[flashAddr] : {16{tick_q}};
  // Erase a page and take program words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= !tick_q;
      if (arrayErase) begin
        for (int i = 0; i < 32; i++) begin
          mem[{arrayErasePage, 5'(i)}] <= 16'h0000;
        end
      end
      if (progValid && progReady) begin
        mem[progWord.addr] <= progWord.data;
      end
    end
  end
endmodule

// File: verif/test_fiap_top.sv
// Self-checking bench for the flash page program/read sequencer
`timescale 1ns/1ps
module test_fiap_top;
  // Shortened erase/write times
  localparam logic [15:0] SHORT = 16'h0028;
  localparam logic [15:0] LONG = 16'h0050;
  localparam logic [12:0] BASE = 13'h00A0; // Page 5 start
  // Row: mode, flag state, trigger kind, expected busy cycles
  typedef struct packed {
    logic [2:0] op;
    logic rfe;
    logic ts;
    logic fl;
    logic rd;
    logic [7:0] hi;
  } fiapRow_t;
  fiapRow_t rows [8] = '{
    '{3'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'h28},
    '{3'h1, 1'h0, 1'h1, 1'h1, 1'h0, 8'h50},
    '{3'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h28},
    '{3'h2, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00},
    '{3'h1, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00},
    '{3'h3, 1'h1, 1'h0, 1'h0, 1'h1, 8'h03},
    '{3'h3, 1'h0, 1'h0, 1'h0, 1'h1, 8'h00},
    '{3'h1, 1'h1, 1'h0, 1'h0, 1'h1, 8'h00}};
  // Stimulus
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic [8:0] stb = 9'h000; // One-hot strobes
  logic [2:0] flashOpSelect = 3'h0;
  logic readFunctionEnable = 1'b0;
  logic eraseWriteTimeSelect = 1'b0;
  logic [1:0] pace = 2'h0;
  // Design outputs
  logic flag, ewTrig, rdTrig, cpuStall, arrayErase, progValid, progReady;
  logic [12:0] flashAddr;
  logic [7:0] data0Low, data0High, erasePage;
  logic [15:0] arrayReadData;
  fiap_pkg::fiapWord_t progWord;
  int fails = 0;
  int samples_checked = 0;
  int hi;
  logic [15:0] v;
  always #50 clk = !clk; // Full system speed throughout
  fiap_top #(.EW_SHORT_CYC(SHORT), .EW_LONG_CYC(LONG), .FIFO_DEPTH(32))
    DUT (.clk(clk), .nrst(nrst), .wrData(wrData), .addrLowWr(stb[0]),
    .addrHighWr(stb[1]), .dataLowWr(stb[2]), .dataHighWr(stb[3]),
    .flashOpSelect(flashOpSelect), .readFunctionEnable(readFunctionEnable),
    .eraseWriteTimeSelect(eraseWriteTimeSelect), .clearWriteBuffer(stb[4]),
    .eraseWriteTriggerSet(stb[5]), .readTriggerSet(stb[6]),
    .unlockSuccess(stb[7]), .enabledFlagClear(stb[8]),
    .eraseWriteEnabledFlag(flag), .eraseWriteTrigger(ewTrig),
    .readTrigger(rdTrig), .cpuStall(cpuStall), .flashAddr(flashAddr),
    .data0Low(data0Low), .data0High(data0High), .arrayErase(arrayErase),
    .arrayErasePage(erasePage), .arrayReadData(arrayReadData),
    .progValid(progValid), .progReady(progReady), .progWord(progWord));
  fiap_flash_model u_flash (.clk(clk), .nrst(nrst), .pace(pace),
    .arrayErase(arrayErase), .arrayErasePage(erasePage),
    .flashAddr(flashAddr), .readTrigger(rdTrig), .progValid(progValid),
    .progReady(progReady), .progWord(progWord),
    .arrayReadData(arrayReadData));
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One strobe pulse, taken at the second edge
  task automatic strobe(input int k, input logic [7:0] d);
    @(posedge clk);
    wrData <= d;
    stb <= 9'h001 << k;
    @(posedge clk);
    stb <= 9'h000;
  endtask
  // Mode levels
  task automatic setMode(input logic [2:0] op, input logic rfe,
      input logic ts);
    @(posedge clk);
    flashOpSelect <= op;
    readFunctionEnable <= rfe;
    eraseWriteTimeSelect <= ts;
  endtask
  // Address pair
  task automatic setAddr(input logic [12:0] a);
    strobe(0, a[7:0]);
    strobe(1, {3'h0, a[12:8]});
  endtask
  // Count busy cycles until both triggers drop
  task automatic waitIdle(output int n);
    n = 0;
    #1;
    while ((ewTrig !== 1'b0 || rdTrig !== 1'b0) && n < 3000) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(cpuStall, 0);
  endtask
  // Read one word through the data registers
  task automatic rd(input logic [12:0] a, output logic [15:0] d);
    int n;
    setAddr(a);
    setMode(3'h3, 1'b1, 1'b0);
    strobe(6, 8'h00);
    waitIdle(n);
    chk(16'(n), 16'h0003);
    d = {data0High, data0Low};
  endtask
  // Watchdog
  initial begin
    #5000000;
    fails++;
    results();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // Table of modes, codes and flag states
    foreach (rows[r]) begin
      strobe(rows[r].fl ? 7 : 8, 8'h00);
      #1;
      chk(flag, rows[r].fl);
      setMode(rows[r].op, rows[r].rfe, rows[r].ts);
      strobe(rows[r].rd ? 6 : 5, 8'h00);
      waitIdle(hi);
      chk(16'(hi), rows[r].hi);
    end
    // Load 33 words, address saturates at word 31
    strobe(7, 8'h00);
    setMode(3'h0, 1'b0, 1'b0);
    setAddr(BASE);
    for (int i = 0; i < 33; i++) begin
      strobe(2, 8'(i));
      #1;
      chk(data0Low, 8'(i));
      if (i == 0) chk(flashAddr, BASE);
      strobe(3, 8'(8'h40 + i));
      #1;
      chk(flashAddr, BASE + ((i < 31) ? i + 1 : 31));
    end
    // Write with the array holding off, FIFO fills
    @(posedge clk);
    pace <= 2'h2;
    strobe(5, 8'h00);
    repeat (60) @(posedge clk);
    strobe(0, 8'h55);
    #1;
    chk({ewTrig, progValid, cpuStall}, 3'h7);
    chk(flashAddr, BASE + 31);
    @(posedge clk);
    pace <= 2'h1;
    waitIdle(hi);
    for (int k = 0; k < 32; k++) begin
      rd(BASE + k, v);
      chk(v, {8'(8'h40 + ((k == 31) ? 32 : k)),
        8'((k == 31) ? 32 : k)});
    end
    // Clear buffer and rewrite the page without erase
    setMode(3'h0, 1'b0, 1'b0);
    strobe(4, 8'h00);
    setAddr(BASE + 2);
    strobe(2, 8'hA5);
    strobe(3, 8'h5A);
    strobe(5, 8'h00);
    waitIdle(hi);
    rd(BASE + 2, v);
    chk(v, 16'h5AA5);
    rd(BASE + 3, v);
    chk(v, 16'h0000);
    // Whole page erase after one dummy high write tags the address
    setMode(3'h1, 1'b0, 1'b0);
    strobe(3, 8'hFF);
    #1;
    chk(flashAddr, BASE + 4);
    strobe(5, 8'h00);
    waitIdle(hi);
    chk(16'(hi), SHORT);
    rd(BASE + 2, v);
    chk(v, 16'h0000);
    // Reset in the middle of an erase clears all status
    setMode(3'h1, 1'b0, 1'b0);
    strobe(3, 8'hC3);
    strobe(5, 8'h00);
    repeat (5) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({flag, ewTrig, rdTrig, cpuStall, data0High}, 12'h000);
    chk({progValid, arrayErase, flashAddr}, 15'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    // First read after release, flag low after reset
    rd(BASE + 4, v);
    chk(v, 16'h0000);
    results();
  end
endmodule
